// file: src/srgc_gate_ctrl.sv
// gate control for the secondary-side synchronous rectifier
`timescale 1ns/1ps
`default_nettype none

module srgc_gate_ctrl (
    input  wire logic                       i_clock,
    input  wire logic                       i_reset,
    input  wire srgc_pkg::srgc_supply_t     i_supply,          // supply comparators
    input  wire srgc_pkg::srgc_cmp_t        i_cmp,             // raw drain comparators
    input  wire logic                       i_strap_cap,       // blank_program_pin cap seen
    input  wire logic [srgc_pkg::OHM_W-1:0] i_blank_set_ohms,  // blank_set_resistor value
    output logic                            o_gate_drive_out,
    output logic                            o_aux_switch_closed,
    output logic [srgc_pkg::THR_W-1:0]      o_threshold_code,  // adaptive threshold
    output logic                            o_running,
    output logic                            o_sleep,
    output logic                            o_fixed_freq_mode
);

    localparam int unsigned CW = srgc_pkg::CW;

    ////////////////////////////////////////////////////////////////////////////
    // state declarations

    srgc_pkg::srgc_cmp_t   cmp_meta_q;                  // first sync stage
    srgc_pkg::srgc_cmp_t   cmp_q;                       // second sync stage
    logic                  below_prev_q;                // delayed drain level
    srgc_pkg::srgc_mode_t  mode_q,   mode_d;            // supply state
    srgc_pkg::srgc_phase_t phase_q,  phase_d;           // cycle phase
    logic                  gate_q;                      // gate drive
    logic                  aux_q;                       // aux switch
    logic                  ff_mode_q;                   // held strap result
    logic [2:0]            strap_cnt_q;                 // strap cycles seen
    logic [CW-1:0]         since_fall_q;                // time since drain fell
    logic                  rise_pend_q;                 // first rise not yet seen
    logic [CW-1:0]         demag_q;                     // last fall-to-rise time
    logic [CW-1:0]         diode_cnt_q;                 // residual conduction
    logic [CW-1:0]         blank_cnt_q;                 // drain-high run length
    logic [CW-1:0]         period_avg_q;                // averaged period
    logic [CW-1:0]         prim_on_q;                   // last rise-to-fall time
    logic [CW-1:0]         ff_target_q;                 // fixed-frequency timer point
    logic [CW-1:0]         qr_target_q;                 // QR timer point
    logic [1:0]            cyc4_q;                      // four-cycle step pacing
    logic [srgc_pkg::THR_W-1:0] thr_q;                  // adaptive threshold code

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // saturating subtract
    function automatic logic [CW-1:0] sat_sub(input logic [CW-1:0] a,
                                              input logic [CW-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction : sat_sub

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // on blanking from resistor, rounded up, at least one cycle
    wire [31:0]   blank_ps    = 32'(i_blank_set_ohms) * srgc_pkg::BLANK_PS_OHM;
    wire [31:0]   blank_cyc32 = (blank_ps + srgc_pkg::CLK_PERIOD_PS - 1)
                                / srgc_pkg::CLK_PERIOD_PS;
    wire [CW-1:0] min_on      = (blank_cyc32 == 32'h0) ? srgc_pkg::ONE_CYC
                                : CW'(blank_cyc32);

    // sleep thresholds
    wire [CW-1:0] sleep_in    = min_on + srgc_pkg::SLEEP_EXTRA_CYC;
    wire [CW-1:0] sleep_out   = min_on + min_on / srgc_pkg::SLEEP_OUT_DIV
                                + srgc_pkg::SLEEP_EXTRA_CYC;

    // edges of the synchronised drain level
    wire below       = cmp_q.drain_below;
    wire fall_raw    = below & ~below_prev_q;
    wire fall_evt    = fall_raw & (phase_q != srgc_pkg::SRGC_BLANK);
    wire first_rise  = ~below & below_prev_q & rise_pend_q;

    // turn-off sources, masked until on blanking is over
    wire past_min    = since_fall_q >= min_on;
    wire adapt_off   = past_min & cmp_q.adapt_trip;
    wire [CW-1:0] timer_pt = ff_mode_q ? ff_target_q : qr_target_q;
    wire timer_off   = past_min & (since_fall_q >= timer_pt);
    wire turn_off    = adapt_off | timer_off;

    // fixed-frequency goal: predicted rise minus lead
    wire [CW-1:0] ff_goal = sat_sub(sat_sub(period_avg_q, prim_on_q),
                                    srgc_pkg::LEAD_CYC);
    wire [CW-1:0] ff_diff = ff_goal - ff_target_q;
    wire [CW-1:0] ff_up   = (ff_diff > srgc_pkg::LEAD_STEP_CYC)
                            ? ff_target_q + srgc_pkg::LEAD_STEP_CYC : ff_goal;

    // off blanking done once drain stayed high long enough
    wire blank_done  = ~below & (blank_cnt_q >= srgc_pkg::OFF_BLANK_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // supply state

    // stop wins everywhere, strap runs five cycles
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            srgc_pkg::SRGC_OFF: begin
                if (i_supply.above_start) mode_d = srgc_pkg::SRGC_STRAP;
            end
            srgc_pkg::SRGC_STRAP: begin
                if (fall_evt && strap_cnt_q == srgc_pkg::STRAP_LAST)
                    mode_d = srgc_pkg::SRGC_SLEEP;
            end
            srgc_pkg::SRGC_SLEEP: begin
                if (first_rise && since_fall_q > sleep_out)
                    mode_d = srgc_pkg::SRGC_RUN;
            end
            srgc_pkg::SRGC_RUN: begin
                if (first_rise && since_fall_q < sleep_in)
                    mode_d = srgc_pkg::SRGC_SLEEP;
            end
            default: mode_d = srgc_pkg::SRGC_OFF;
        endcase
        if (!i_supply.above_stop) mode_d = srgc_pkg::SRGC_OFF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle phase

    // on at falling drain, off on first trigger, then blanking
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            srgc_pkg::SRGC_WAIT: begin
                if (fall_evt && mode_q == srgc_pkg::SRGC_RUN)
                    phase_d = srgc_pkg::SRGC_ON;
            end
            srgc_pkg::SRGC_ON: begin
                if (turn_off) phase_d = srgc_pkg::SRGC_DIODE;
            end
            srgc_pkg::SRGC_DIODE: begin
                if (!below) phase_d = srgc_pkg::SRGC_BLANK;
            end
            srgc_pkg::SRGC_BLANK: begin
                if (blank_done) phase_d = srgc_pkg::SRGC_WAIT;
            end
            default: phase_d = srgc_pkg::SRGC_WAIT;
        endcase
        if (mode_q != srgc_pkg::SRGC_RUN && phase_q != srgc_pkg::SRGC_BLANK
            && phase_q != srgc_pkg::SRGC_DIODE)
            phase_d = srgc_pkg::SRGC_WAIT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparator synchroniser

    // two flops, only the second stage is used
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cmp_meta_q   <= '0;
            cmp_q        <= '0;
            below_prev_q <= 1'b0;
        end else begin
            cmp_meta_q   <= i_cmp;
            cmp_q        <= cmp_meta_q;
            below_prev_q <= cmp_q.drain_below;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers and gate

    // gate follows the on phase, dropped at once when supply stops
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_q  <= srgc_pkg::SRGC_OFF;
            phase_q <= srgc_pkg::SRGC_WAIT;
            gate_q  <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            phase_q <= phase_d;
            gate_q  <= (phase_d == srgc_pkg::SRGC_ON) & i_supply.above_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // aux switch

    // close below aux level, open at start level; close wins
    always_ff @(posedge i_clock) begin
        if (i_reset) aux_q <= 1'b0;
        else if (!i_supply.above_aux) aux_q <= 1'b1;
        else if (i_supply.above_start) aux_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap sensing

    // sample each strap cycle, hold until supply stop
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            strap_cnt_q <= 3'h0;
            ff_mode_q   <= 1'b0;
        end else if (mode_q == srgc_pkg::SRGC_OFF) begin
            strap_cnt_q <= 3'h0;
            ff_mode_q   <= 1'b0;
        end else if (mode_q == srgc_pkg::SRGC_STRAP && fall_evt) begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
            ff_mode_q   <= i_strap_cap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timing measurements

    // time since fall, demag time, primary on time
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            since_fall_q <= '0;
            rise_pend_q  <= 1'b0;
            demag_q      <= '0;
            prim_on_q    <= '0;
        end else begin
            if (fall_evt) begin
                since_fall_q <= '0;
                prim_on_q    <= sat_sub(since_fall_q, demag_q);
            end else if (since_fall_q != '1) begin
                since_fall_q <= since_fall_q + srgc_pkg::ONE_CYC;
            end
            if (fall_evt) rise_pend_q <= 1'b1;
            else if (first_rise) rise_pend_q <= 1'b0;
            if (first_rise) demag_q <= since_fall_q;
        end
    end

    // residual diode and post-off blanking counters
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            diode_cnt_q <= '0;
            blank_cnt_q <= '0;
        end else begin
            if (phase_q == srgc_pkg::SRGC_ON) diode_cnt_q <= '0;
            else if (phase_q == srgc_pkg::SRGC_DIODE && below
                     && diode_cnt_q != '1)
                diode_cnt_q <= diode_cnt_q + srgc_pkg::ONE_CYC;
            if (phase_q != srgc_pkg::SRGC_BLANK || below) blank_cnt_q <= '0;
            else if (blank_cnt_q != '1)
                blank_cnt_q <= blank_cnt_q + srgc_pkg::ONE_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lead timer targets

    // period average, paced fixed-frequency point, QR point
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            period_avg_q <= '0;
            ff_target_q  <= '0;
            qr_target_q  <= '0;
            cyc4_q       <= 2'h0;
        end else begin
            if (fall_evt) begin
                period_avg_q <= period_avg_q - (period_avg_q >> 2)
                                + (since_fall_q >> 2);
                cyc4_q <= cyc4_q + 2'h1;
                if (ff_goal < ff_target_q) ff_target_q <= ff_goal;
                else if (cyc4_q == srgc_pkg::LEAD_PACE_LAST) ff_target_q <= ff_up;
            end
            if (first_rise)
                qr_target_q <= sat_sub(since_fall_q, srgc_pkg::LEAD_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // adaptive threshold

    // short residual raises code (earlier off), long lowers it
    always_ff @(posedge i_clock) begin
        if (i_reset) thr_q <= srgc_pkg::THR_MIN;
        else if (mode_q != srgc_pkg::SRGC_RUN && mode_q != srgc_pkg::SRGC_SLEEP)
            thr_q <= srgc_pkg::THR_MIN;
        else if (phase_q == srgc_pkg::SRGC_DIODE && !below) begin
            if (diode_cnt_q < srgc_pkg::DIODE_TARGET_CYC && thr_q != srgc_pkg::THR_MAX)
                thr_q <= thr_q + 6'h01;
            else if (diode_cnt_q > srgc_pkg::DIODE_TARGET_CYC
                     && thr_q != srgc_pkg::THR_MIN)
                thr_q <= thr_q - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_gate_drive_out    = gate_q;
    assign o_aux_switch_closed = aux_q;
    assign o_threshold_code    = thr_q;
    assign o_running           = (mode_q == srgc_pkg::SRGC_RUN);
    assign o_sleep             = (mode_q == srgc_pkg::SRGC_SLEEP);
    assign o_fixed_freq_mode   = ff_mode_q;

endmodule : srgc_gate_ctrl

`default_nettype wire

// file: src/srgc_pkg.sv
// constants, types and carriers for the synchronous-rectifier gate control
package srgc_pkg;

    // clock period and timing figures in their own units
    localparam int unsigned CLK_PERIOD_PS   = 4000;  // 250 MHz clock
    localparam int unsigned BLANK_PS_OHM    = 12;    // on blanking per ohm of resistor
    localparam int unsigned DIODE_TARGET_NS = 330;   // residual diode conduction goal
    localparam int unsigned LEAD_NS         = 280;   // timer anticipation
    localparam int unsigned LEAD_STEP_NS    = 56;    // timer step in fixed frequency
    localparam int unsigned OFF_BLANK_NS    = 500;   // fixed blanking after turn-off
    localparam int unsigned SLEEP_EXTRA_NS  = 300;   // added to on blanking for sleep

    // derived cycle counts
    localparam int unsigned CW = 16;                 // counter width
    localparam logic [CW-1:0] DIODE_TARGET_CYC =
        CW'(DIODE_TARGET_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [CW-1:0] LEAD_CYC = CW'(LEAD_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [CW-1:0] LEAD_STEP_CYC = CW'(LEAD_STEP_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [CW-1:0] OFF_BLANK_CYC =
        CW'((OFF_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CW-1:0] SLEEP_EXTRA_CYC =
        CW'(SLEEP_EXTRA_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [CW-1:0] ONE_CYC = 16'h0001;
    localparam logic [CW-1:0] SLEEP_OUT_DIV = 16'h0005;  // sleep exit margin, a fifth of blanking
    localparam logic [1:0] LEAD_PACE_LAST = 2'h3;        // fourth cycle of timer step pacing

    // strap sensing length, adaptive threshold layout
    localparam logic [2:0] STRAP_LAST   = 3'h4;      // fifth switching cycle
    localparam int unsigned THR_W       = 6;         // threshold code width
    localparam logic [THR_W-1:0] THR_MIN = 6'h00;    // lowest threshold, start point
    localparam logic [THR_W-1:0] THR_MAX = 6'h3F;
    localparam int unsigned OHM_W       = 18;        // resistor value width

    // supply state, gray along off, strap, sleep, run
    typedef enum logic [1:0] {
        SRGC_OFF   = 2'h0,
        SRGC_STRAP = 2'h1,
        SRGC_SLEEP = 2'h3,
        SRGC_RUN   = 2'h2
    } srgc_mode_t;

    // switching-cycle phase, gray along wait, on, diode, blank
    typedef enum logic [1:0] {
        SRGC_WAIT  = 2'h0,
        SRGC_ON    = 2'h1,
        SRGC_DIODE = 2'h3,
        SRGC_BLANK = 2'h2
    } srgc_phase_t;

    // supply comparator levels
    typedef struct packed {
        logic above_start;   // supply above supply_start_level
        logic above_aux;     // supply above aux_switch_level
        logic above_stop;    // supply above supply_stop_level
    } srgc_supply_t;

    // drain-sense comparator outputs
    typedef struct packed {
        logic drain_below;   // drain_sense_input below cycle_threshold
        logic adapt_trip;    // adaptive_off_comparator fired
    } srgc_cmp_t;

endpackage : srgc_pkg

// file: verification/srgc_flyback_model.sv
// flyback secondary model producing the drain comparator levels
`timescale 1ns/1ps
`default_nettype none
module srgc_flyback_model (
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_start,  // primary switch turns off
    input  wire logic [15:0]       i_cond,   // demagnetisation length in cycles
    input  wire logic [15:0]       i_trip,   // adaptive trip point, 0 = at drain rise
    output var srgc_pkg::srgc_cmp_t o_cmp
);
    logic [15:0] cnt_q;  // cycles into conduction, 0 = drain high
    // secondary conducts for the demagnetisation time, whatever the gate does
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cnt_q <= 16'h0000;
        end else if (i_start) begin
            cnt_q <= 16'h0001;
        end else if (cnt_q != 16'h0000 && cnt_q < i_cond) begin
            cnt_q <= cnt_q + 16'h0001;
        end else begin
            cnt_q <= 16'h0000;
        end
    end
    // drain high trips the off comparator too
    assign o_cmp.drain_below = (cnt_q != 16'h0000);
    assign o_cmp.adapt_trip  = (cnt_q == 16'h0000) || (i_trip != 16'h0000 && cnt_q > i_trip);
endmodule : srgc_flyback_model
`default_nettype wire

// file: verification/srgc_gate_ctrl_sva.sv
// assertion checker for the gate control, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module srgc_gate_ctrl_sva (
    input wire logic                       i_clock,
    input wire logic                       i_reset,
    input wire srgc_pkg::srgc_supply_t     i_supply,
    input wire srgc_pkg::srgc_cmp_t        i_cmp,
    input wire logic                       i_strap_cap,
    input wire logic [srgc_pkg::OHM_W-1:0] i_blank_set_ohms,
    input wire logic                       o_gate_drive_out,
    input wire logic                       o_aux_switch_closed,
    input wire logic [srgc_pkg::THR_W-1:0] o_threshold_code,
    input wire logic                       o_running,
    input wire logic                       o_sleep,
    input wire logic                       o_fixed_freq_mode
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    logic [31:0] min_on_w;  // programmed on blanking in cycles
    logic [31:0] on_cnt_q;  // cycles the gate has stood high
    logic [31:0] on_cnt_d;
    ////////////////////////////////////////////////////////////////////////////
    // ceiling of ohms times blanking per ohm over the clock period
    assign min_on_w = ({14'h0000, i_blank_set_ohms} * 32'h0000000C + 32'h00000F9F) / 32'h00000FA0;
    assign on_cnt_d = o_gate_drive_out ? on_cnt_q + 32'h00000001 : 32'h00000000;
    // gate-high length counter
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            on_cnt_q <= 32'h00000000;
        end else begin
            on_cnt_q <= on_cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_stop_off;
        !i_supply.above_stop |=> !o_running && !o_sleep && !o_gate_drive_out;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("gate control active below stop");
    property p_aux_set;
        !i_supply.above_aux |=> o_aux_switch_closed;
    endproperty
    a_aux_set: assert property (p_aux_set) else $error("aux switch not closed");
    property p_aux_clr;
        i_supply.above_aux && i_supply.above_start |=> !o_aux_switch_closed;
    endproperty
    a_aux_clr: assert property (p_aux_clr) else $error("aux switch not opened");
    property p_gate_run;
        $rose(o_gate_drive_out) |-> o_running && $past(i_cmp.drain_below, 2);
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("gate rose without cause");
    property p_min_on;
        $fell(o_gate_drive_out) && $past(i_supply.above_stop) |-> on_cnt_q + 32'h00000002 >= min_on_w;
    endproperty
    a_min_on: assert property (p_min_on) else $error("gate shorter than on blanking");
    property p_thr_step;
        $changed(o_threshold_code) && o_running && $past(o_running)
            |-> (o_threshold_code - $past(o_threshold_code)) == 6'h01
             || (o_threshold_code - $past(o_threshold_code)) == 6'h3F;
    endproperty
    a_thr_step: assert property (p_thr_step) else $error("threshold jumped");
    property p_thr_gate;
        $changed(o_threshold_code) && o_running |-> !o_gate_drive_out && !$past(o_gate_drive_out);
    endproperty
    a_thr_gate: assert property (p_thr_gate) else $error("threshold moved while gate on");
    property p_strap_hold;
        (o_running || o_sleep) && $past(o_running || o_sleep) |-> $stable(o_fixed_freq_mode);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap result changed");
    // main scenarios reached
    c_gate_on: cover property ($rose(o_gate_drive_out));
    c_sleep: cover property ($rose(o_sleep));
    c_ff_run: cover property (o_running && o_fixed_freq_mode);
    c_thr: cover property ($changed(o_threshold_code) && o_running);
endmodule : srgc_gate_ctrl_sva

bind srgc_gate_ctrl srgc_gate_ctrl_sva srgc_gate_ctrl_sva_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_supply(i_supply), .i_cmp(i_cmp),
    .i_strap_cap(i_strap_cap), .i_blank_set_ohms(i_blank_set_ohms),
    .o_gate_drive_out(o_gate_drive_out), .o_aux_switch_closed(o_aux_switch_closed),
    .o_threshold_code(o_threshold_code), .o_running(o_running), .o_sleep(o_sleep),
    .o_fixed_freq_mode(o_fixed_freq_mode)
);
`default_nettype wire

// file: verification/srgc_gate_ctrl_tb.sv
// self-checking testbench for the gate control
`timescale 1ns/1ps
`default_nettype none
module srgc_gate_ctrl_tb;
    logic                   clock = 1'b0;
    logic                   reset;
    srgc_pkg::srgc_supply_t supply;
    srgc_pkg::srgc_cmp_t    cmp;
    logic                   strap_cap;
    logic [17:0]            ohms;
    logic                   gate, aux, run, slp, ffm;
    logic [5:0]             thr;
    logic                   start;
    logic [15:0]            cond, trip;
    int                     error_cnt, checks_done, w_cnt;
    int                     min_on, c_len, exp_thr;
    int                     lo_q[$], hi_q[$];  // expected gate width bounds
    always #2 clock = ~clock;
    srgc_gate_ctrl srgc_gate_ctrl_i (.i_clock(clock), .i_reset(reset), .i_supply(supply),
        .i_cmp(cmp), .i_strap_cap(strap_cap), .i_blank_set_ohms(ohms),
        .o_gate_drive_out(gate), .o_aux_switch_closed(aux), .o_threshold_code(thr),
        .o_running(run), .o_sleep(slp), .o_fixed_freq_mode(ffm));
    srgc_flyback_model srgc_flyback_model_i (.i_clock(clock), .i_reset(reset),
        .i_start(start), .i_cond(cond), .i_trip(trip), .o_cmp(cmp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic chk_rng(input int lo, input int hi, input int seen);
        checks_done++;
        if (seen < lo || seen > hi) begin
            error_cnt++;
            $display("mismatch gate width expected %0d..%0d seen %0d", lo, hi, seen);
        end
    endtask : chk_rng
    task automatic finish_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // step n edges, then drive just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // one switching cycle; lo below zero means no gate pulse expected
    task automatic frame(input int c, input int t, input int gap, input int lo, input int hi);
        if (lo >= 0) begin
            lo_q.push_back(lo);
            hi_q.push_back(hi);
        end
        cond = 16'(c);
        trip = 16'(t);
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(c + gap);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////
    // monitor: measure each gate pulse and match it to the oldest note
    always @(posedge clock) begin
        if (gate === 1'b1) begin
            w_cnt++;
        end else if (w_cnt != 0) begin
            if (lo_q.size() == 0) begin
                chk_rng(1, 0, w_cnt);
            end else begin
                chk_rng(lo_q.pop_front(), hi_q.pop_front(), w_cnt);
            end
            w_cnt = 0;
        end
    end
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(88));
        reset = 1'b1;
        supply = 3'h0;
        strap_cap = 1'b0;
        start = 1'b0;
        cond = 16'h0000;
        trip = 16'h0000;
        ohms = 18'(33000 + $urandom % 20000);
        min_on = (int'(ohms) * srgc_pkg::BLANK_PS_OHM + srgc_pkg::CLK_PERIOD_PS - 1)
                 / srgc_pkg::CLK_PERIOD_PS;
        c_len = min_on + min_on / 5 + 75 + 120 + $urandom % 40;
        cyc(16);
        reset = 1'b0;
        chk("running", 16'h0000, 16'(run));
        cyc(2);
        chk("aux closed", 16'h0001, 16'(aux));
        supply = 3'h7;
        cyc(2);
        chk("aux open", 16'h0000, 16'(aux));
        for (int m = 0; m < 2; m++) begin
            supply.above_stop = 1'b0;
            cyc(3);
            chk("off running", 16'h0000, 16'({run, slp, gate}));
            strap_cap = m[0];
            supply = 3'h7;
            cyc(2);
            repeat (5) frame(50, 0, 200, -1, 0);
            chk("sleep after strap", 16'h0001, 16'(slp));
            chk("strap mode", 16'(m), 16'(ffm));
            strap_cap = ~m[0];
            exp_thr = 0;
            frame(c_len, 0, 250, -1, 0);
            chk("running", 16'h0001, 16'(run));
            // constant period keeps the primary's period growth at zero
            if (m == 0) begin
                for (int i = 0; i < 4; i++) begin
                    frame(c_len, 0, 250, c_len - 74, c_len - 66);
                    exp_thr++;
                    chk("threshold up", 16'(exp_thr), 16'(thr));
                end
            end
            for (int i = 0; i < 4; i++) begin
                frame(c_len, c_len - 150, (i == 3) ? 60 : 250,
                      (m == 0) ? c_len - 153 : min_on - 2, c_len - 147);
                if (m == 0) begin
                    exp_thr--;
                    chk("threshold down", 16'(exp_thr), 16'(thr));
                end
            end
            frame(100, 0, 250, -1, 0);
            chk("strap held", 16'(m), 16'(ffm));
            frame(min_on + 20, 0, 250, (m == 0) ? min_on + 16 : min_on - 2, min_on + 24);
            chk("sleep entry", 16'h0001, 16'(slp));
        end
        cyc(4);
        chk("pulses left", 16'h0000, 16'(lo_q.size()));
        finish_test();
    end
endmodule : srgc_gate_ctrl_tb
`default_nettype wire
